// ---- slc_map.svh ----
// register offsets, field positions, reset values and timing counts of the subclock low power switch
// Functional notes
// RULE1 - writing 70H to standby control moves system clock to subsystem oscillator
// RULE2 - clock status register shows whether subsystem clock is really selected
// RULE3 - once on subsystem clock, writing 74H stops the main oscillator
// RULE4 - writing 70H restarts main oscillator while system clock stays on subclock
// RULE5 - after software waits settle time, 00H write selects main clock
// RULE6 - software never clears stop and select bits together while main is stopped
// RULE7 - settle time register sets wake wait only for STOP on main clock
// RULE8 - address, address/data and read/write strobe pins float in STOP and IDLE
// RULE9 - address strobe pin floats in STOP and IDLE
// RULE10 - clearing ADC mode bit 7 shuts the converter down
// RULE11 - clearing a D/A channel enable floats its analog output
// RULE12 - pin in control mode follows the peripheral, not the latch
// RULE13 - pin in port mode follows output latch and direction register
// RULE14 - system clock stays on subclock from 70H until explicit 00H
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

// byte offsets on the register bus
`define SLC_OFS_STANDBY 6'h00
`define SLC_OFS_CLKSTAT 6'h04
`define SLC_OFS_SETTLE 6'h08
`define SLC_OFS_ADCMODE 6'h0C
`define SLC_OFS_DAC0 6'h10
`define SLC_OFS_DAC1 6'h14
`define SLC_OFS_PLATCH 6'h18
`define SLC_OFS_PDIR 6'h1C
`define SLC_OFS_PCTRL 6'h20

// standby control fields
`define SLC_STB_MODE_LSB 0
`define SLC_STB_MODE_MSB 1
`define SLC_STB_OSCSTOP_BIT 2
`define SLC_STB_CK_LSB 4
`define SLC_STB_CK_MSB 6

// clock status fields
`define SLC_STAT_SUB_BIT 0
`define SLC_STAT_OSCRUN_BIT 1
`define SLC_STAT_MODE_LSB 2
`define SLC_STAT_SETTLE_BIT 4

// converter fields
`define SLC_ADC_RUN_BIT 7
`define SLC_DAC_EN_BIT 0

// reset values
`define SLC_RST_STANDBY 8'h00
`define SLC_RST_SETTLE 3'h4
`define SLC_RST_PORT 8'h00
`define SLC_RST_PDIR 8'hFF

// timing: switch-over in cycles, settle base in cycles
`define SLC_SWITCH_CYCLES 8
`define SLC_SETTLE_BASE 16

`endif

// ---- slc_pkg.sv ----
// types of the subclock low power switch
package slc_pkg;
	typedef enum logic [1:0] {
		CLK_MAIN = 2'b00,
		CLK_SWITCH = 2'b01,
		CLK_SUB = 2'b10
	} slc_clk_state_t;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_HALT = 2'b01,
		MODE_STOP = 2'b10,
		MODE_IDLE = 2'b11
	} slc_mode_t;
endpackage

// ---- slc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module slc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ---- slc_top.sv ----
// system clock source, oscillator, standby pin and analog power control
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "slc_map.svh"
module slc_top #(
	parameter int SWITCH_CYCLES = `SLC_SWITCH_CYCLES,
	parameter int SETTLE_BASE = `SLC_SETTLE_BASE,
	parameter int PORT_W = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// avalon-mm slave
	input wire logic [5:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	// standby wake pin
	input wire logic WAKE,
	// clock control
	output logic SYSCLK_SEL_SUB,
	output logic MAIN_OSC_RUN,
	output logic [1:0] STANDBY_MODE,
	// external bus pin enables, low while driving
	output logic EXT_BUS_OE_N,
	output logic RDWR_OE_N,
	output logic ADDR_STROBE_OE_N,
	// analog power
	output logic ADC_RUN,
	output logic [1:0] DAC_OUT_EN,
	// port pins
	input wire logic [PORT_W-1:0] PERIPH_OUT,
	input wire logic [PORT_W-1:0] PERIPH_OE,
	output logic [PORT_W-1:0] PORT_OUT,
	output logic [PORT_W-1:0] PORT_OE_N
);
	// bus handshake
	logic waitreq, next_waitreq, wr_take, lane0;
	logic [31:0] rdata, next_rdata;

	// software-visible registers and their next values
	logic [7:0] standby_control_reg, adc_mode_reg, dac_chan0_mode_reg, dac_chan1_mode_reg;
	logic [7:0] next_standby, next_adc, next_dac0, next_dac1;
	logic [2:0] osc_settle_time_reg, next_settle_reg;
	logic [PORT_W-1:0] port_latch, port_dir, port_ctrl;
	logic [PORT_W-1:0] next_latch, next_dir, next_ctrl;

	// clock source and standby state
	slc_pkg::slc_clk_state_t clk_state, next_clk_state;
	slc_pkg::slc_mode_t mode, next_mode;
	logic [15:0] sw_cnt, next_sw_cnt, settle_cnt, next_settle_cnt;
	logic settling, next_settling, osc_run, next_osc_run, sel_sub, next_sel_sub;
	logic wake_s, wake_d, next_wake_d, stb_wr, sub_req;
	logic [7:0] wbyte;

	// registered pin drive
	logic ext_oe_n, next_ext_oe_n, adc_run;
	logic [1:0] dac_en, next_dac_en;
	logic [PORT_W-1:0] pout, poe_n, next_pout, next_poe_n;

	assign READDATA = rdata;
	assign WAITREQUEST = waitreq;
	assign SYSCLK_SEL_SUB = sel_sub;
	assign MAIN_OSC_RUN = osc_run;
	assign STANDBY_MODE = mode;
	assign EXT_BUS_OE_N = ext_oe_n;
	assign RDWR_OE_N = ext_oe_n;
	assign ADDR_STROBE_OE_N = ext_oe_n;
	assign ADC_RUN = adc_run;
	assign DAC_OUT_EN = dac_en;
	assign PORT_OUT = pout;
	assign PORT_OE_N = poe_n;

	// wake is a pin, so it is synchronised before anything looks at it
	slc_sync #(.W(1)) u_wake_sync (
		.clk(CLK),
		.reset(RESET),
		.d(WAKE),
		.q(wake_s)
	);

	// one wait cycle per access keeps read data and waitrequest both registered
	assign wr_take = WRITE && !waitreq;
	assign lane0 = BYTEENABLE[0];
	assign wbyte = WRITEDATA[7:0];
	assign stb_wr = wr_take && lane0 && (ADDRESS == `SLC_OFS_STANDBY);
	assign sub_req = (wbyte[`SLC_STB_CK_MSB:`SLC_STB_CK_LSB] != 3'h0);

	// bus handshake and read mux
	always_comb begin
		next_waitreq = !((READ || WRITE) && waitreq);
		next_rdata = rdata;
		if (READ && waitreq) begin
			next_rdata = 32'h0;
			case (ADDRESS)
				`SLC_OFS_STANDBY: next_rdata[7:0] = standby_control_reg;
				`SLC_OFS_CLKSTAT: begin
					next_rdata[`SLC_STAT_SUB_BIT] = (clk_state == slc_pkg::CLK_SUB); // [RULE2]
					next_rdata[`SLC_STAT_OSCRUN_BIT] = osc_run;
					next_rdata[`SLC_STAT_MODE_LSB +: 2] = mode;
					next_rdata[`SLC_STAT_SETTLE_BIT] = settling;
				end
				`SLC_OFS_SETTLE: next_rdata[2:0] = osc_settle_time_reg;
				`SLC_OFS_ADCMODE: next_rdata[7:0] = adc_mode_reg;
				`SLC_OFS_DAC0: next_rdata[7:0] = dac_chan0_mode_reg;
				`SLC_OFS_DAC1: next_rdata[7:0] = dac_chan1_mode_reg;
				`SLC_OFS_PLATCH: next_rdata[PORT_W-1:0] = port_latch;
				`SLC_OFS_PDIR: next_rdata[PORT_W-1:0] = port_dir;
				`SLC_OFS_PCTRL: next_rdata[PORT_W-1:0] = port_ctrl;
				default: next_rdata = 32'h0; // unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			waitreq <= 1'b1;
			rdata <= 32'h0;
		end else begin
			waitreq <= next_waitreq;
			rdata <= next_rdata;
		end
	end

	// software-written registers; only byte lane 0 carries data
	always_comb begin
		next_standby = standby_control_reg;
		next_settle_reg = osc_settle_time_reg;
		next_adc = adc_mode_reg;
		next_dac0 = dac_chan0_mode_reg;
		next_dac1 = dac_chan1_mode_reg;
		next_latch = port_latch;
		next_dir = port_dir;
		next_ctrl = port_ctrl;
		if (wr_take && lane0) begin
			case (ADDRESS)
				`SLC_OFS_STANDBY: next_standby = wbyte;
				`SLC_OFS_SETTLE: next_settle_reg = wbyte[2:0];
				`SLC_OFS_ADCMODE: next_adc = wbyte;
				`SLC_OFS_DAC0: next_dac0 = wbyte;
				`SLC_OFS_DAC1: next_dac1 = wbyte;
				`SLC_OFS_PLATCH: next_latch = WRITEDATA[PORT_W-1:0]; // [RULE13]
				`SLC_OFS_PDIR: next_dir = WRITEDATA[PORT_W-1:0]; // [RULE13]
				`SLC_OFS_PCTRL: next_ctrl = WRITEDATA[PORT_W-1:0];
				default: next_standby = standby_control_reg; // unmapped writes ignored
			endcase
		end
		// released standby shows as run mode in the register too
		if (mode != slc_pkg::MODE_RUN && next_mode == slc_pkg::MODE_RUN && !stb_wr) begin
			next_standby[`SLC_STB_MODE_MSB:`SLC_STB_MODE_LSB] = 2'b00;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			standby_control_reg <= `SLC_RST_STANDBY;
			osc_settle_time_reg <= `SLC_RST_SETTLE;
			adc_mode_reg <= 8'h00;
			dac_chan0_mode_reg <= 8'h00;
			dac_chan1_mode_reg <= 8'h00;
			port_latch <= `SLC_RST_PORT;
			port_dir <= `SLC_RST_PDIR;
			port_ctrl <= `SLC_RST_PORT;
		end else begin
			standby_control_reg <= next_standby;
			osc_settle_time_reg <= next_settle_reg;
			adc_mode_reg <= next_adc;
			dac_chan0_mode_reg <= next_dac0;
			dac_chan1_mode_reg <= next_dac1;
			port_latch <= next_latch;
			port_dir <= next_dir;
			port_ctrl <= next_ctrl;
		end
	end

	// clock source machine: main, switching over, subsystem
	always_comb begin
		next_clk_state = clk_state;
		next_sw_cnt = sw_cnt;
		next_osc_run = osc_run;
		case (clk_state)
			slc_pkg::CLK_MAIN: begin
				if (stb_wr && sub_req) begin
					next_clk_state = slc_pkg::CLK_SWITCH; // [RULE1]
					next_sw_cnt = 16'(SWITCH_CYCLES - 1);
				end
			end
			slc_pkg::CLK_SWITCH: begin
				if (sw_cnt == 16'h0000) begin
					next_clk_state = slc_pkg::CLK_SUB; // [RULE1]
				end else begin
					next_sw_cnt = sw_cnt - 16'h0001;
				end
			end
			slc_pkg::CLK_SUB: begin
				// only an explicit 00H style write with the oscillator running returns to main
				if (stb_wr && !sub_req && osc_run) begin
					next_clk_state = slc_pkg::CLK_MAIN; // [RULE5] [RULE14]
				end
			end
			default: next_clk_state = slc_pkg::CLK_MAIN;
		endcase
		if (stb_wr) begin
			if (!wbyte[`SLC_STB_OSCSTOP_BIT]) begin
				next_osc_run = 1'b1; // [RULE4]
			end else if (clk_state == slc_pkg::CLK_SUB) begin
				next_osc_run = 1'b0; // [RULE3]
			end
		end
		// a combined clear while stopped only restarts the oscillator; the clock stays on sub
		if (clk_state == slc_pkg::CLK_SUB && !osc_run) begin
			next_clk_state = slc_pkg::CLK_SUB; // [RULE6] [RULE14]
		end
		next_sel_sub = (next_clk_state == slc_pkg::CLK_SUB) || (next_clk_state == slc_pkg::CLK_SWITCH && sel_sub);
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			clk_state <= slc_pkg::CLK_MAIN;
			sw_cnt <= 16'h0000;
			osc_run <= 1'b1;
			sel_sub <= 1'b0;
		end else begin
			clk_state <= next_clk_state;
			sw_cnt <= next_sw_cnt;
			osc_run <= next_osc_run;
			sel_sub <= next_sel_sub;
		end
	end

	// standby mode and wake, with settle wait after STOP on main clock only
	always_comb begin
		next_mode = mode;
		next_settling = settling;
		next_settle_cnt = settle_cnt;
		next_wake_d = wake_s;
		if (stb_wr) begin
			next_mode = slc_pkg::slc_mode_t'(wbyte[`SLC_STB_MODE_MSB:`SLC_STB_MODE_LSB]);
			next_settling = 1'b0;
		end else if (settling) begin
			if (settle_cnt == 16'h0000) begin
				next_settling = 1'b0;
				next_mode = slc_pkg::MODE_RUN;
			end else begin
				next_settle_cnt = settle_cnt - 16'h0001;
			end
		end else if (wake_s && !wake_d && mode != slc_pkg::MODE_RUN) begin
			if (mode == slc_pkg::MODE_STOP && clk_state == slc_pkg::CLK_MAIN) begin
				next_settling = 1'b1; // [RULE7]
				next_settle_cnt = 16'((SETTLE_BASE << osc_settle_time_reg) - 1);
			end else begin
				next_mode = slc_pkg::MODE_RUN; // [RULE7]
			end
		end
		// bus pins float in STOP and IDLE, driven otherwise
		next_ext_oe_n = (next_mode == slc_pkg::MODE_STOP) || (next_mode == slc_pkg::MODE_IDLE); // [RULE8] [RULE9]
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			mode <= slc_pkg::MODE_RUN;
			settling <= 1'b0;
			settle_cnt <= 16'h0000;
			wake_d <= 1'b0;
			ext_oe_n <= 1'b0;
		end else begin
			mode <= next_mode;
			settling <= next_settling;
			settle_cnt <= next_settle_cnt;
			wake_d <= next_wake_d;
			ext_oe_n <= next_ext_oe_n;
		end
	end

	// converter power
	always_comb begin
		next_dac_en[0] = dac_chan0_mode_reg[`SLC_DAC_EN_BIT]; // [RULE11]
		next_dac_en[1] = dac_chan1_mode_reg[`SLC_DAC_EN_BIT]; // [RULE11]
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			adc_run <= 1'b0;
			dac_en <= 2'b00;
		end else begin
			adc_run <= adc_mode_reg[`SLC_ADC_RUN_BIT]; // [RULE10]
			dac_en <= next_dac_en;
		end
	end

	// per pin: control mode follows the peripheral, port mode follows latch and direction
	genvar gi;
	generate
		for (gi = 0; gi < PORT_W; gi++) begin : g_pin
			always_comb begin
				if (port_ctrl[gi]) begin
					next_pout[gi] = PERIPH_OUT[gi]; // [RULE12]
					next_poe_n[gi] = !PERIPH_OE[gi]; // [RULE12]
				end else begin
					next_pout[gi] = port_latch[gi]; // [RULE13]
					next_poe_n[gi] = port_dir[gi]; // [RULE13]
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (RESET) begin
			pout <= '0;
			poe_n <= '1;
		end else begin
			pout <= next_pout;
			poe_n <= next_poe_n;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	chk_sub_switch_req: assert property ( // [RULE1]
		(stb_wr && sub_req && clk_state == slc_pkg::CLK_MAIN) |=> clk_state == slc_pkg::CLK_SWITCH)
		else $error("subclock request did not start switch-over");
	chk_switch_done: assert property ( // [RULE2]
		(clk_state == slc_pkg::CLK_SWITCH && sw_cnt == 16'h0000) |=> clk_state == slc_pkg::CLK_SUB ##1 sel_sub)
		else $error("switch-over did not complete");
	chk_stop_main_osc: assert property ( // [RULE3]
		$fell(osc_run) |-> $past(clk_state) == slc_pkg::CLK_SUB)
		else $error("main oscillator stopped while not on subclock");
	chk_restart_osc: assert property ( // [RULE4]
		(stb_wr && !wbyte[`SLC_STB_OSCSTOP_BIT] && clk_state == slc_pkg::CLK_SUB && sub_req)
		|=> osc_run && clk_state == slc_pkg::CLK_SUB)
		else $error("oscillator restart left subclock");
	chk_return_main: assert property ( // [RULE5]
		(stb_wr && !sub_req && osc_run && clk_state == slc_pkg::CLK_SUB) |=> ##1 !sel_sub)
		else $error("00H write did not select main clock");
	chk_sub_hold: assert property ( // [RULE14]
		(clk_state == slc_pkg::CLK_SUB && !(stb_wr && !sub_req)) |=> clk_state == slc_pkg::CLK_SUB)
		else $error("left subclock without a return write");
	chk_bus_float: assert property ( // [RULE8]
		(mode == slc_pkg::MODE_STOP || mode == slc_pkg::MODE_IDLE) |-> EXT_BUS_OE_N && RDWR_OE_N)
		else $error("bus pins driven in STOP or IDLE");
	chk_strobe_float: assert property ( // [RULE9]
		$rose(mode == slc_pkg::MODE_IDLE) |-> ADDR_STROBE_OE_N)
		else $error("address strobe driven in IDLE");
	chk_adc_off: assert property ( // [RULE10]
		!adc_mode_reg[`SLC_ADC_RUN_BIT] |=> !ADC_RUN)
		else $error("converter ran with run bit clear");
	chk_dac_float: assert property ( // [RULE11]
		(!dac_chan0_mode_reg[`SLC_DAC_EN_BIT] ##1 !dac_chan0_mode_reg[`SLC_DAC_EN_BIT]) |-> !DAC_OUT_EN[0])
		else $error("dac channel 0 driven while disabled");
	chk_settle_main_only: assert property ( // [RULE7]
		$rose(settling) |-> clk_state == slc_pkg::CLK_MAIN && mode == slc_pkg::MODE_STOP)
		else $error("settle wait outside STOP on main clock");
	chk_port_mode: assert property ( // [RULE13]
		(!port_ctrl[0] && $stable(port_latch[0])) |=> PORT_OUT[0] == $past(port_latch[0]))
		else $error("port pin did not follow latch");
endmodule

// ---- test_slc_top.sv ----
// self-checking bench for the subclock low power switch
`timescale 1ns/10ps
`include "slc_map.svh"
module test_slc_top;
	// clock and reset
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	// register bus
	logic [5:0] ADDRESS = 6'h00;
	logic READ = 1'b0;
	logic WRITE = 1'b0;
	logic [31:0] WRITEDATA = 32'h0;
	logic [3:0] BYTEENABLE = 4'hF;
	logic [31:0] READDATA;
	logic WAITREQUEST;
	// pins
	logic WAKE = 1'b0;
	logic SYSCLK_SEL_SUB, MAIN_OSC_RUN, EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N, ADC_RUN;
	logic [1:0] STANDBY_MODE, DAC_OUT_EN;
	logic [7:0] PERIPH_OUT = 8'h00;
	logic [7:0] PERIPH_OE = 8'h00;
	logic [7:0] PORT_OUT, PORT_OE_N;
	int n_errors = 0;
	int check_count = 0;
	logic [31:0] rd_val;
	int n;

	// short counts keep the run small; expectations derive from these
	localparam int SW = 2;
	localparam int SB = 1;

	slc_top #(.SWITCH_CYCLES(SW), .SETTLE_BASE(SB), .PORT_W(8)) i_slc_top (.CLK(CLK), .RESET(RESET),
		.ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
		.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .WAKE(WAKE), .SYSCLK_SEL_SUB(SYSCLK_SEL_SUB),
		.MAIN_OSC_RUN(MAIN_OSC_RUN), .STANDBY_MODE(STANDBY_MODE), .EXT_BUS_OE_N(EXT_BUS_OE_N),
		.RDWR_OE_N(RDWR_OE_N), .ADDR_STROBE_OE_N(ADDR_STROBE_OE_N), .ADC_RUN(ADC_RUN), .DAC_OUT_EN(DAC_OUT_EN),
		.PERIPH_OUT(PERIPH_OUT), .PERIPH_OE(PERIPH_OE), .PORT_OUT(PORT_OUT), .PORT_OE_N(PORT_OE_N));

	// 250 MHz clock
	initial begin
		forever #2 CLK = ~CLK;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask

	// request held until waitrequest is sampled low at a rising edge
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= d;
		BYTEENABLE <= be;
		WRITE <= 1'b1;
		do @(posedge CLK); while (WAITREQUEST !== 1'b0);
		WRITE <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge CLK);
		ADDRESS <= a;
		READ <= 1'b1;
		do @(posedge CLK); while (WAITREQUEST !== 1'b0);
		d = READDATA;
		READ <= 1'b0;
		#1;
	endtask

	// pulse the wake pin and count cycles until the mode is back to run
	task automatic wake_count(output int c);
		@(posedge CLK);
		WAKE <= 1'b1;
		c = 0;
		do begin
			@(posedge CLK);
			c++;
		end while (STANDBY_MODE !== 2'b00 && c < 100);
		WAKE <= 1'b0;
		#1;
	endtask

	task automatic complete_run;
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge CLK);
		n_errors++;
		complete_run;
	end

	initial begin
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		#1;
		chk("reset pins", 32'h0000_0040, {SYSCLK_SEL_SUB, MAIN_OSC_RUN, STANDBY_MODE, ADC_RUN, DAC_OUT_EN, 1'b0});
		chk("reset oe", 32'h0000_00FF, {PORT_OE_N, EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N} >> 3);
		rd(`SLC_OFS_SETTLE, rd_val);
		chk("settle reset", 32'h4, rd_val & 32'h7);
		// unmapped place reads zero; a write without byte 0 is dropped
		rd(6'h3C, rd_val);
		chk("unmapped", 32'h0, rd_val);
		wr(`SLC_OFS_ADCMODE, 32'h80, 4'hE);
		step(2);
		chk("adc be0", 32'h0, ADC_RUN);
		// converter shutdown
		wr(`SLC_OFS_ADCMODE, 32'h80);
		step(2);
		chk("adc run", 32'h1, ADC_RUN);
		wr(`SLC_OFS_ADCMODE, 32'h00);
		step(2);
		chk("adc off", 32'h0, ADC_RUN);
		for (int i = 0; i < 2; i++) begin
			wr(i ? `SLC_OFS_DAC1 : `SLC_OFS_DAC0, 32'h1);
			step(2);
			chk("dac on", 32'h1 << i, DAC_OUT_EN);
			wr(i ? `SLC_OFS_DAC1 : `SLC_OFS_DAC0, 32'h0);
			step(2);
			chk("dac off", 32'h0, DAC_OUT_EN);
		end
		// port mode, then upper half handed to the peripheral
		wr(`SLC_OFS_PLATCH, 32'hA5);
		wr(`SLC_OFS_PDIR, 32'h0F);
		@(posedge CLK);
		PERIPH_OUT <= 8'h3C;
		PERIPH_OE <= 8'hC0;
		step(2);
		chk("port out", 32'hA5, PORT_OUT);
		chk("port oe", 32'h0F, PORT_OE_N);
		wr(`SLC_OFS_PCTRL, 32'hF0);
		step(2);
		chk("mix out", 32'h35, PORT_OUT);
		chk("mix oe", 32'h3F, PORT_OE_N);
		// stop on main clock waits the settle count after wake
		wr(`SLC_OFS_SETTLE, 32'h3);
		wr(`SLC_OFS_STANDBY, 32'h02);
		step(2);
		chk("stop float", 32'h7, {EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N});
		chk("port hold", 32'h35, PORT_OUT);
		wake_count(n);
		chk("stop settle", 32'h1, n >= (SB << 3) && n < (SB << 3) + 8);
		step(2);
		chk("bus drive", 32'h0, {EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N});
		// idle is not governed by the settle count
		wr(`SLC_OFS_STANDBY, 32'h03);
		step(2);
		chk("idle float", 32'h7, {EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N});
		wake_count(n);
		chk("idle wake", 32'h1, n < 6);
		// halt keeps the bus driven and wakes at once
		wr(`SLC_OFS_STANDBY, 32'h01);
		step(2);
		chk("halt drive", 32'h0, {EXT_BUS_OE_N, RDWR_OE_N, ADDR_STROBE_OE_N});
		wake_count(n);
		chk("halt wake", 32'h1, n < 6);
		// stop request from main does not stop the oscillator
		wr(`SLC_OFS_STANDBY, 32'h74);
		step(2);
		chk("74 on main", 32'h1, MAIN_OSC_RUN);
		wr(`SLC_OFS_STANDBY, 32'h00);
		step(2);
		// switch to subclock, not before the switch-over count
		wr(`SLC_OFS_STANDBY, 32'h70);
		chk("sel early", 32'h0, SYSCLK_SEL_SUB);
		step(SW + 2);
		chk("sel sub", 32'h1, SYSCLK_SEL_SUB);
		rd(`SLC_OFS_CLKSTAT, rd_val);
		chk("status sub", 32'h1, rd_val[`SLC_STAT_SUB_BIT]);
		// stop from subclock returns at once, settle count not used
		wr(`SLC_OFS_STANDBY, 32'h72);
		step(2);
		wake_count(n);
		chk("sub stop wake", 32'h1, n < 6);
		wr(`SLC_OFS_STANDBY, 32'h74);
		step(2);
		chk("osc stop", 32'h1, {MAIN_OSC_RUN, SYSCLK_SEL_SUB});
		// combined clear while stopped keeps the subclock
		wr(`SLC_OFS_STANDBY, 32'h00);
		step(SW + 4);
		chk("combined clr", 32'h1, SYSCLK_SEL_SUB);
		wr(`SLC_OFS_STANDBY, 32'h74);
		step(2);
		wr(`SLC_OFS_STANDBY, 32'h70);
		step(SW + 4);
		chk("osc restart", 32'h3, {MAIN_OSC_RUN, SYSCLK_SEL_SUB});
		rd(`SLC_OFS_CLKSTAT, rd_val);
		chk("status still", 32'h1, rd_val[`SLC_STAT_SUB_BIT]);
		wr(`SLC_OFS_STANDBY, 32'h00);
		step(2);
		chk("back main", 32'h2, {MAIN_OSC_RUN, SYSCLK_SEL_SUB});
		rd(`SLC_OFS_CLKSTAT, rd_val);
		chk("status main", 32'h0, rd_val[`SLC_STAT_SUB_BIT]);
		// reset in mid-run while on the subclock brings everything back to main
		wr(`SLC_OFS_STANDBY, 32'h70);
		step(SW + 2);
		chk("sel before rst", 32'h1, SYSCLK_SEL_SUB);
		@(posedge CLK);
		RESET <= 1'b1;
		step(2);
		@(posedge CLK);
		RESET <= 1'b0;
		#1;
		chk("rst clock", 32'h1, {SYSCLK_SEL_SUB, MAIN_OSC_RUN});
		rd(`SLC_OFS_STANDBY, rd_val);
		chk("rst standby", 32'h0, rd_val);
		rd(`SLC_OFS_CLKSTAT, rd_val);
		chk("rst status", 32'h0, rd_val[`SLC_STAT_SUB_BIT]);
		complete_run;
	end
endmodule
